// ===== rtl/ued_consts.vh
`ifndef UED_CONSTS_VH
`define UED_CONSTS_VH

// register word indices on the wishbone slave, decoded from address bits 5:2
`define UED_REG_EN_SET      4'h0
`define UED_REG_EN_CLR      4'h1
`define UED_REG_FLAGS       4'h2
`define UED_REG_CTRL        4'h3
`define UED_REG_DESC_BASE   4'h4
`define UED_REG_STATUS      4'h5

// event bit positions, shared by enable and flag registers
`define UED_BIT_DONE0       0
`define UED_BIT_DONE1       1
`define UED_BIT_FAIL0       2
`define UED_BIT_FAIL1       3
`define UED_BIT_SETUP       4
`define UED_BIT_STALL_BANK0_IRQ_EN      5
`define UED_BIT_STALL_BANK1_IRQ_EN      6
`define UED_EVT_W           7

// control register fields
`define UED_CTRL_ACTIVE     0

// descriptor layout in system ram
`define UED_DESC_PTR_OFF    32'h0000_0000
`define UED_DESC_SIZE_OFF   32'h0000_0004
`define UED_DESC_BANK_STEP  32'h0000_0010

// packet size word fields
`define UED_PS_ZLP          31
`define UED_PS_CODE_HI      30
`define UED_PS_CODE_LO      28
`define UED_PS_MULTI_HI     27
`define UED_PS_MULTI_LO     14
`define UED_PS_COUNT_HI     13
`define UED_PS_COUNT_LO     0

// size codes
`define UED_SIZE_BASE       11'h008
`define UED_SIZE_CODE_MAX   3'h7
`define UED_SIZE_MAX        11'h3FF

// reset values
`define UED_EN_RESET        7'h00
`define UED_BASE_RESET      32'h0000_0000

`endif

// ===== rtl/ued_desc_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "ued_consts.vh"

module ued_desc_decode (
    input  wire [31:0] size_word_i,
    output wire        auto_zero_length_packet_o,
    output wire [10:0] max_size_o,
    output wire [13:0] multi_o,
    output wire [13:0] count_o
);

    wire [2:0] code;

    assign code       = size_word_i[`UED_PS_CODE_HI:`UED_PS_CODE_LO];
    assign auto_zero_length_packet_o = size_word_i[`UED_PS_ZLP];
    // 8 bytes doubled per code, top code is 1023
    assign max_size_o = (code == `UED_SIZE_CODE_MAX) ? `UED_SIZE_MAX
                                                     : (`UED_SIZE_BASE << code);
    assign multi_o    = size_word_i[`UED_PS_MULTI_HI:`UED_PS_MULTI_LO];
    assign count_o    = size_word_i[`UED_PS_COUNT_HI:`UED_PS_COUNT_LO];

endmodule

`default_nettype wire

// ===== rtl/ued_endpoint.v
// How it works
// - writing zero leaves an enable unchanged
// - bit 5 enables bank 0 stall
// - bit 4 enables setup received
// - bit 3 enables bank 1 transfer fail
// - bank 0 transfer fail enable exists
// - bit 1 enables bank 1 transfer done
// - bit 0 enables bank 0 transfer done
// - buffer pointer is absolute ram address
// - auto_zero_length_packet bit makes hardware send zlp
// - size code gives max packet size
// - fail0 at bit 2, stall_bank1_irq_en at 6
// - clear view matches; reset clears enables
// - multi packet field accumulates transfer bytes
// - byte count gives next or last size
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "ued_consts.vh"

module ued_endpoint (
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         irq_o,
    // usb side
    input  wire        usb_reset_i,
    input  wire        xact_start_i,
    input  wire        xact_bank_i,
    input  wire        xact_in_i,
    input  wire        xact_setup_i,
    input  wire        xact_end_i,
    input  wire        xact_fail_i,
    input  wire [13:0] xact_rx_count_i,
    input  wire        stall_i,
    input  wire        stall_bank_i,
    output reg         desc_valid_o,
    output reg  [31:0] buf_ptr_o,
    output reg  [13:0] tx_count_o,
    output reg  [10:0] max_size_o,
    output reg         zlp_needed_o,
    output reg         busy_o,
    // descriptor ram master
    output reg         mem_req_o,
    output reg         mem_we_o,
    output reg  [31:0] mem_addr_o,
    output reg  [31:0] mem_wdata_o,
    input  wire [31:0] mem_rdata_i,
    input  wire        mem_ack_i
);

    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_PTR  = 5'b00010;
    localparam [4:0] S_SIZE = 5'b00100;
    localparam [4:0] S_LINK = 5'b01000;
    localparam [4:0] S_WB   = 5'b10000;

    reg  [4:0]             state;
    reg  [`UED_EVT_W-1:0]  irq_en;
    reg  [`UED_EVT_W-1:0]  flags;
    reg                    endpoint_active;
    reg  [31:0]            desc_base;
    reg                    cur_bank;
    reg                    cur_in;
    reg                    cur_setup;
    reg  [31:0]            size_word;
    reg  [`UED_EVT_W-1:0]  evt;
    reg  [31:0]            next_size;
    reg  [31:0]            rd_data;

    wire                   wb_hit;
    wire                   wb_wr;
    wire [3:0]             reg_idx;
    wire                   dec_zlp;
    wire [10:0]            dec_max;
    wire [13:0]            dec_multi;
    wire [13:0]            dec_count;
    wire [13:0]            xfer_bytes;
    wire [31:0]            bank_addr;

    // =====================================================
    // functions
    // =====================================================
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  sel;
        integer      k;
        begin
            merge_bytes = old_val;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    merge_bytes[k*8 +: 8] = new_val[k*8 +: 8];
                end
            end
        end
    endfunction

    function [`UED_EVT_W-1:0] bank_evt;
        input bank;
        input [1:0] kind;
        begin
            bank_evt = {`UED_EVT_W{1'b0}};
            case (kind)
                2'd0: bank_evt[bank ? `UED_BIT_DONE1 : `UED_BIT_DONE0] = 1'b1;
                2'd1: bank_evt[bank ? `UED_BIT_FAIL1 : `UED_BIT_FAIL0] = 1'b1;
                default: bank_evt[bank ? `UED_BIT_STALL_BANK1_IRQ_EN : `UED_BIT_STALL_BANK0_IRQ_EN] = 1'b1;
            endcase
        end
    endfunction

    // =====================================================
    // descriptor decode
    // =====================================================
    ued_desc_decode u_decode (
        .size_word_i (size_word),
        .auto_zero_length_packet_o  (dec_zlp),
        .max_size_o  (dec_max),
        .multi_o     (dec_multi),
        .count_o     (dec_count)
    );

    assign xfer_bytes = cur_in ? dec_count : xact_rx_count_i;
    assign bank_addr  = desc_base + (cur_bank ? `UED_DESC_BANK_STEP : 32'h0000_0000);

    always @* begin
        next_size = size_word;
        next_size[`UED_PS_MULTI_HI:`UED_PS_MULTI_LO] = dec_multi + xfer_bytes;
        if (!cur_in) begin
            next_size[`UED_PS_COUNT_HI:`UED_PS_COUNT_LO] = xact_rx_count_i;
        end
    end

    // =====================================================
    // wishbone slave
    // =====================================================
    assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr   = wb_hit && wb_we_i;
    assign reg_idx = wb_adr_i[5:2];

    always @* begin
        rd_data = 32'h0000_0000;
        case (reg_idx)
            `UED_REG_EN_SET:    rd_data[`UED_EVT_W-1:0] = irq_en;
            `UED_REG_EN_CLR:    rd_data[`UED_EVT_W-1:0] = irq_en;
            `UED_REG_FLAGS:     rd_data[`UED_EVT_W-1:0] = flags;
            `UED_REG_CTRL:      rd_data[`UED_CTRL_ACTIVE] = endpoint_active;
            `UED_REG_DESC_BASE: rd_data = desc_base;
            `UED_REG_STATUS:    rd_data[7:0] = {cur_setup, cur_in, cur_bank, state};
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= (wb_hit && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    // =====================================================
    // control registers
    // =====================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            endpoint_active <= 1'b0;
            desc_base       <= `UED_BASE_RESET;
        end else if (wb_wr) begin
            if (reg_idx == `UED_REG_CTRL && wb_sel_i[0]) begin
                endpoint_active <= wb_dat_i[`UED_CTRL_ACTIVE];
            end
            if (reg_idx == `UED_REG_DESC_BASE) begin
                desc_base <= merge_bytes(desc_base, wb_dat_i, wb_sel_i) & 32'hFFFF_FFFC;
            end
        end
    end

    // enables: set view and clear view share one store
    always @(posedge clk_i) begin
        if (rst_i || usb_reset_i || !endpoint_active) begin
            irq_en <= `UED_EN_RESET;
        end else if (wb_wr && wb_sel_i[0]) begin
            if (reg_idx == `UED_REG_EN_SET) begin
                irq_en <= irq_en | wb_dat_i[`UED_EVT_W-1:0];
            end else if (reg_idx == `UED_REG_EN_CLR) begin
                irq_en <= irq_en & ~wb_dat_i[`UED_EVT_W-1:0];
            end
        end
    end

    // =====================================================
    // event flags and interrupt
    // =====================================================
    always @* begin
        evt = {`UED_EVT_W{1'b0}};
        if (stall_i) begin
            evt = evt | bank_evt(stall_bank_i, 2'd2);
        end
        if (state == S_LINK && xact_end_i && xact_fail_i) begin
            evt = evt | bank_evt(cur_bank, 2'd1);
        end
        if (state == S_WB && mem_ack_i) begin
            evt = evt | bank_evt(cur_bank, 2'd0);
            evt[`UED_BIT_SETUP] = cur_setup;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            flags <= {`UED_EVT_W{1'b0}};
            irq_o <= 1'b0;
        end else begin
            // set beats a same-cycle clear
            if (wb_wr && wb_sel_i[0] && reg_idx == `UED_REG_FLAGS) begin
                flags <= (flags & ~wb_dat_i[`UED_EVT_W-1:0]) | evt;
            end else begin
                flags <= flags | evt;
            end
            irq_o <= |(flags & irq_en);
        end
    end

    // =====================================================
    // descriptor engine
    // =====================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            state        <= S_IDLE;
            cur_bank     <= 1'b0;
            cur_in       <= 1'b0;
            cur_setup    <= 1'b0;
            size_word    <= 32'h0000_0000;
            mem_req_o    <= 1'b0;
            mem_we_o     <= 1'b0;
            mem_addr_o   <= 32'h0000_0000;
            mem_wdata_o  <= 32'h0000_0000;
            desc_valid_o <= 1'b0;
            buf_ptr_o    <= 32'h0000_0000;
            tx_count_o   <= 14'h0000;
            max_size_o   <= 11'h000;
            zlp_needed_o <= 1'b0;
            busy_o       <= 1'b0;
        end else if (!endpoint_active || usb_reset_i) begin
            state        <= S_IDLE;
            mem_req_o    <= 1'b0;
            mem_we_o     <= 1'b0;
            desc_valid_o <= 1'b0;
            zlp_needed_o <= 1'b0;
            busy_o       <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (xact_start_i) begin
                        cur_bank   <= xact_bank_i;
                        cur_in     <= xact_in_i;
                        cur_setup  <= xact_setup_i;
                        mem_req_o  <= 1'b1;
                        mem_we_o   <= 1'b0;
                        mem_addr_o <= desc_base + (xact_bank_i ? `UED_DESC_BANK_STEP
                                                               : 32'h0000_0000)
                                      + `UED_DESC_PTR_OFF;
                        busy_o     <= 1'b1;
                        state      <= S_PTR;
                    end
                end
                S_PTR: begin
                    if (mem_ack_i) begin
                        buf_ptr_o <= mem_rdata_i;
                        mem_req_o <= 1'b0;
                        state     <= S_SIZE;
                    end
                end
                S_SIZE: begin
                    if (mem_req_o && mem_ack_i) begin
                        size_word <= mem_rdata_i;
                        mem_req_o <= 1'b0;
                        state     <= S_LINK;
                    end else if (!mem_req_o) begin
                        mem_req_o  <= 1'b1;
                        mem_addr_o <= bank_addr + `UED_DESC_SIZE_OFF;
                    end
                end
                S_LINK: begin
                    desc_valid_o <= !xact_end_i;
                    tx_count_o   <= dec_count;
                    max_size_o   <= dec_max;
                    // trailing zlp only when a full packet ends an auto_zero_length_packet in
                    zlp_needed_o <= cur_in && dec_zlp && (dec_count != 14'h0000)
                                    && ({3'b000, dec_max} == dec_count);
                    if (xact_end_i) begin
                        zlp_needed_o <= 1'b0;
                        if (xact_fail_i) begin
                            busy_o <= 1'b0;
                            state  <= S_IDLE;
                        end else begin
                            mem_req_o   <= 1'b1;
                            mem_we_o    <= 1'b1;
                            mem_addr_o  <= bank_addr + `UED_DESC_SIZE_OFF;
                            mem_wdata_o <= next_size;
                            state       <= S_WB;
                        end
                    end
                end
                S_WB: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o  <= 1'b0;
                        busy_o    <= 1'b0;
                        state     <= S_IDLE;
                    end
                end
                default: begin
                    state     <= S_IDLE;
                    mem_req_o <= 1'b0;
                    busy_o    <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== dv/ued_endpoint_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ued_endpoint_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        usb_reset_i,
    input wire logic        desc_valid_o,
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic        mem_ack_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic rd_ack = wb_ack_o && !wb_we_i;
    wire logic rd_mem = mem_req_o && mem_ack_i && !mem_we_o;
    // ==========
    // bus answer
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_unmapped;
        rd_ack && wb_adr_i[7:6] == 2'b00 && wb_adr_i[5:2] > 4'h5 |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_en_upper;
        rd_ack && wb_adr_i[7:3] == 5'h00 |-> wb_dat_o[31:7] == 25'h000_0000;
    endproperty
    a_en_upper: assert property (p_en_upper) else $error("enable upper bits set");
    // ==========
    // descriptor fetch
    property p_mem_hold;
        disable iff (rst_i || usb_reset_i)
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
    property p_size_next;
        disable iff (rst_i || usb_reset_i)
        rd_mem && !mem_addr_o[2] |=> !mem_req_o ##1
            (mem_req_o && mem_addr_o == $past(mem_addr_o, 2) + 32'h0000_0004);
    endproperty
    a_size_next: assert property (p_size_next) else $error("size word not next");
    property p_dv_after;
        rd_mem && mem_addr_o[2] |-> ##[1:2] desc_valid_o;
    endproperty
    a_dv_after: assert property (p_dv_after) else $error("descriptor not valid");
    property p_usb_rst;
        usb_reset_i |=> !desc_valid_o && !mem_req_o;
    endproperty
    a_usb_rst: assert property (p_usb_rst) else $error("engine not idled");
    c_desc: cover property ($rose(desc_valid_o));
    c_write: cover property (wb_ack_o && wb_we_i);
    c_urst: cover property (usb_reset_i);
endmodule
bind ued_endpoint ued_endpoint_checker ued_endpoint_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .usb_reset_i(usb_reset_i), .desc_valid_o(desc_valid_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i)
);
`default_nettype wire

// ===== dv/ued_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module ued_ram_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [1:0]  lat_i,
    output var  logic [31:0] rdata_o,
    output var  logic        ack_o
);
    logic [31:0] mem [0:63];
    int          wait_n = 0;
    initial begin
        rdata_o = 32'h0000_0000;
        ack_o = 1'b0;
    end
    // ==========
    // stall lat_i cycles; data toggles when not answering
    always @(posedge clk_i) begin
        if (ack_o || !req_i) begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            wait_n <= 0;
        end else if (wait_n < lat_i) begin
            wait_n <= wait_n + 1;
            rdata_o <= ~rdata_o;
        end else begin
            ack_o <= 1'b1;
            if (we_i)
                mem[addr_i[7:2]] <= wdata_i;
            else
                rdata_o <= mem[addr_i[7:2]];
        end
    end
endmodule
`default_nettype wire

// ===== dv/ued_endpoint_test.sv
`timescale 1ns/100ps
`default_nettype none
module ued_endpoint_test;
    localparam [7:0] ASET = 8'h00, ACLR = 8'h04, AFLG = 8'h08, ACTL = 8'h0C, ABAS = 8'h10;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq, urst = 0;
    logic        xst = 0, xbk = 0, xin = 0, xsu = 0, xend = 0, xfail = 0, stl = 0, stlb = 0;
    logic        dv, dvq = 0, zlp, busy, mreq, mwe, mack;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 4'hF, wsel = 4'hF;
    logic [1:0]  lat = 0;
    logic [13:0] rxc = 0, txc;
    logic [10:0] mx;
    logic [31:0] dat = 0, rdat, ptr, maddr, mwd, mrd;
    logic [31:0] rq [$];
    logic [57:0] dq [$];
    int          mismatches = 0, n_tests = 0, seed = 83673, cyc_n = 0;
    ued_endpoint ued_endpoint_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .usb_reset_i(urst),
        .xact_start_i(xst), .xact_bank_i(xbk), .xact_in_i(xin), .xact_setup_i(xsu),
        .xact_end_i(xend), .xact_fail_i(xfail), .xact_rx_count_i(rxc), .stall_i(stl),
        .stall_bank_i(stlb), .desc_valid_o(dv), .buf_ptr_o(ptr), .tx_count_o(txc),
        .max_size_o(mx), .zlp_needed_o(zlp), .busy_o(busy), .mem_req_o(mreq),
        .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mrd),
        .mem_ack_i(mack));
    ued_ram_model ued_ram_model_inst (.clk_i(clk_i), .req_i(mreq), .we_i(mwe),
        .addr_i(maddr), .wdata_i(mwd), .lat_i(lat), .rdata_o(mrd), .ack_o(mack));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, wsel};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n == 50)
            mismatches++;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wbr(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic pulse_stall(input logic bk);
        {stlb, stl} <= {bk, 1'b1};
        @(posedge clk_i);
        stl <= 1'b0;
    endtask
    // ==========
    // result monitor
    always @(posedge clk_i) begin
        dvq <= dv;
        cyc_n++;
        if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
            check("wb_dat_o", rdat, rq.pop_front());
        if (dv === 1'b1 && dvq !== 1'b1)
            check("descriptor", {ptr, mx, txc, zlp}, dq.pop_front());
        if (cyc_n == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    // ==========
    // main sequence
    initial begin
        int i, n;
        logic [31:0] e, r, ps;
        logic [13:0] cnt, rx;
        logic [10:0] mxs;
        logic b, in, su, fl, z;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1, ACTL, 1);
        for (i = 0; i < 7; i++) begin
            wb(1, ASET, 32'h1 << i);
            wb(1, ASET, 0);
            e = (32'h2 << i) - 1;
            wbr(ASET, e);
            wbr(ACLR, e);
        end
        wb(1, ACLR, 32'h0000_0055);
        wbr(ASET, 32'h0000_002A);
        r = $random(seed);
        wb(1, ASET, r);
        wbr(ASET, (r | 32'h2A) & 32'h7F);
        wb(1, 8'h3C, r);
        wbr(8'h3C, 0);
        urst <= 1'b1;
        @(posedge clk_i);
        urst <= 1'b0;
        wbr(ASET, 0);
        // byte lane 0 off: enable write ignored, base merges low byte only
        wsel = 4'hE;
        wb(1, ASET, 32'h0000_007F);
        wsel = 4'h1;
        wb(1, ABAS, 32'hFFFF_FF43);
        wsel = 4'hF;
        wbr(ASET, 0);
        wbr(ABAS, 32'h0000_0040);
        wb(1, ASET, 32'h7F);
        wb(1, ACTL, 0);
        wbr(ACLR, 0);
        wb(1, ACTL, 1);
        pulse_stall(1'b0);
        wbr(AFLG, 32'h20);
        check("irq_o", irq, 0);
        wb(1, ASET, 32'h20);
        wbr(ASET, 32'h20);
        check("irq_o", irq, 1);
        wb(1, AFLG, 32'h20);
        wbr(AFLG, 0);
        check("irq_o", irq, 0);
        wb(1, ASET, 32'h7F);
        wb(1, ABAS, 32'h40);
        for (i = 0; i < 8; i++) begin
            {in, b} = i[1:0];
            su = (i == 4);
            fl = (i == 5);
            z = $random(seed);
            mxs = (i == 7) ? 11'h3FF : 11'h008 << i;
            cnt = i[2] ? {3'b000, mxs} : 14'($random(seed)) & 14'h03FF;
            r = $random(seed) & 32'hFFFF_FFFC;
            ps = {z, i[2:0], 14'h0000, cnt};
            ued_ram_model_inst.mem[16 + 4 * b] = r;
            ued_ram_model_inst.mem[17 + 4 * b] = ps;
            ued_ram_model_inst.mem[20 - 4 * b] = ~r;
            ued_ram_model_inst.mem[21 - 4 * b] = ~ps;
            dq.push_back({r, mxs, cnt, in & z & (cnt == {3'b000, mxs})});
            lat <= 2'($random(seed));
            {xbk, xin, xsu, xst} <= {b, in, su, 1'b1};
            @(posedge clk_i);
            xst <= 1'b0;
            for (n = 0; dv !== 1'b1 && n < 100; n++)
                @(posedge clk_i);
            if (n == 100)
                mismatches++;
            rx = 14'($random(seed)) & 14'h03FF;
            {xfail, rxc, xend} <= {fl, rx, 1'b1};
            @(posedge clk_i);
            xend <= 1'b0;
            for (n = 0; busy !== 1'b0 && n < 100; n++)
                @(posedge clk_i);
            if (n == 100)
                mismatches++;
            e = {18'h0_0000, in ? cnt : rx};
            check("size word", ued_ram_model_inst.mem[17 + 4 * b],
                fl ? ps : {z, i[2:0], e[13:0], e[13:0]});
            wbr(8'h14, {24'h00_0000, su, in, b, 5'h01});
            pulse_stall(b);
            e = (fl ? 32'h4 : 32'h1) << b | (su ? 32'h10 : 32'h0) | 32'h20 << b;
            wbr(AFLG, e);
            check("irq_o", irq, 1);
            wb(1, AFLG, 32'h7F);
        end
        check("queues left", rq.size() + dq.size(), 0);
        end_sim();
    end
endmodule
`default_nettype wire
